/* File: pkg/dac_ctrl_params.svh */
// Purpose: Constants for the control byte decoder.
// Assumes: Included by its bare name.
// Notes: Bit positions count within one received byte.
`ifndef DAC_CTRL_PARAMS_SVH
`define DAC_CTRL_PARAMS_SVH
`define DEVICE_ADDR 6'h05
`define XFER_DATA 2'h0
`define XFER_STATUS 2'h2
`define SEL_VOLUME 2'h0
`define SEL_NONE 2'h1
`define SEL_EMPH 2'h2
`define SEL_DEFAULT 2'h3
`define DEFAULT_BYTE 8'hC1
`define CLK_RATIO_RST 2'h0
`define FORMAT_RST 3'h0
`define VOLUME_RST 6'h00
`define EMPH_RST 2'h0
`define MUTE_RST 1'h0
`define VOL_MAX_CODE 6'h3C
`define VOL_MAX_ATTEN 6'h3C
`endif

/* File: pkg/dac_ctrl_pkg.sv */
// Purpose: Types for the control byte decoder.
// Assumes: Nothing.
// Notes: Enumerations of decoded settings.
package dac_ctrl_pkg;
  typedef enum logic [1:0] {RATIO_512 = 2'h0, RATIO_384 = 2'h1, RATIO_256 = 2'h2, RATIO_BAD = 2'h3} clk_ratio_e;
  typedef enum logic [2:0] {FMT_I2S = 3'h0, FMT_LSB16 = 3'h1, FMT_LSB18 = 3'h2, FMT_LSB20 = 3'h3,
                            FMT_MSB = 3'h4} in_format_e;
  typedef enum logic [1:0] {EMPH_OFF = 2'h0, EMPH_32K = 2'h1, EMPH_44K1 = 2'h2, EMPH_48K = 2'h3} emphasis_e;
endpackage

/* File: rtl/audio_dac_control_byte_decoder.sv */
// Purpose: Receive control bytes on the serial control link and hold the converter settings.
// Assumes: Host drives serial clock, data and address mode; data sampled on rising serial clock, LSB first.
// Notes: Settings live in the clk domain; bytes cross by toggle handshake.
// Contract
// - Address byte low two bits pick data type (00) or status type (10).
// - Top two data byte bits pick the target register; six bits hold value.
// - Settings change only after all eight bits of a byte arrive.
// - Status byte 00: bits 5:4 clock ratio, bits 3:1 input format.
// - Clock ratio 00 is 512fs, 01 is 384fs, 10 is 256fs, 11 unused.
// - Format 000 I2S, 001/010/011 LSB 16/18/20, 100 MSB-justified.
// - Data byte 00 stores six-bit volume; data byte 01 is ignored.
// - Data byte 10: bits 4:3 emphasis selector, bit 2 mute.
// - Emphasis 00 off, 01 32 kHz, 10 44.1 kHz, 11 48 kHz.
// - Volume codes 0 and 1 give 0 dB, steps 1 dB up to 111011, 111100 gives 60 dB, 111111 silent.
// - Mute bit 1 soft-mutes output, 0 passes audio.
`include "dac_ctrl_params.svh"
`timescale 1ns/10ps
`default_nettype none
module audio_dac_control_byte_decoder
(
  // System clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Serial control link.
  input wire logic ctrl_serial_clock,
  input wire logic ctrl_serial_data,
  input wire logic ctrl_address_mode,
  // Decoded settings.
  output var dac_ctrl_pkg::clk_ratio_e clkRatio,
  output var dac_ctrl_pkg::in_format_e inputFormat,
  output logic [5:0] volumeCode,
  output logic [5:0] attenDb,
  output logic silence,
  output var dac_ctrl_pkg::emphasis_e emphasis,
  output logic softMute
);
  import dac_ctrl_pkg::*;

  logic rstSync1_q;
  logic rstSync2_q;
  logic linkRst1_q;
  logic linkRst2_q;
  logic [7:0] shift_q;
  logic [2:0] bitCnt_q;
  logic modeLast_q;
  logic [7:0] byte_q;
  logic isAddr_q;
  logic byteTgl_q;
  logic tglSync1_q;
  logic tglSync2_q;
  logic tglSync3_q;
  logic [7:0] capByte_q;
  logic capAddr_q;
  logic [7:0] rxByte_q;
  logic rxAddr_q;
  logic byteValid_q;
  logic selected_q;
  logic [1:0] xferType_q;
  logic [1:0] clkRatio_q;
  logic [2:0] inputFormat_q;
  logic [5:0] volume_q;
  logic [1:0] emph_q;
  logic mute_q;
  logic [5:0] attenDb_q;
  logic silence_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end
    else
    begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  wire rstN = rstSync2_q;

  // Link-side reset release synchronised to the link clock.
  always_ff @(posedge ctrl_serial_clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      linkRst1_q <= 1'b0;
      linkRst2_q <= 1'b0;
    end
    else
    begin
      linkRst1_q <= 1'b1;
      linkRst2_q <= linkRst1_q;
    end
  end
  wire linkRstN = linkRst2_q;

  // A change of address mode restarts byte counting.
  wire modeChange = ctrl_address_mode != modeLast_q;
  wire [2:0] cntBase = modeChange ? 3'h0 : bitCnt_q;
  wire [7:0] shiftNext = {ctrl_serial_data, shift_q[7:1]};
  wire byteDone = cntBase == 3'h7;

  always_ff @(posedge ctrl_serial_clock or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      shift_q <= 8'h00;
      bitCnt_q <= 3'h0;
      modeLast_q <= 1'b0;
    end
    else
    begin
      shift_q <= shiftNext;
      bitCnt_q <= cntBase + 3'h1;
      modeLast_q <= ctrl_address_mode;
    end
  end

  // Only whole bytes are handed over.
  always_ff @(posedge ctrl_serial_clock or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      byte_q <= 8'h00;
      isAddr_q <= 1'b0;
      byteTgl_q <= 1'b0;
    end
    else if (byteDone)
    begin
      byte_q <= shiftNext;
      isAddr_q <= ctrl_address_mode;
      byteTgl_q <= ~byteTgl_q;
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      tglSync1_q <= 1'b0;
      tglSync2_q <= 1'b0;
      tglSync3_q <= 1'b0;
    end
    else
    begin
      tglSync1_q <= byteTgl_q;
      tglSync2_q <= tglSync1_q;
      tglSync3_q <= tglSync2_q;
    end
  end
  wire byteArrived = tglSync2_q != tglSync3_q;

  // Byte words are stable for many system clocks once the toggle is seen.
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      capByte_q <= 8'h00;
      capAddr_q <= 1'b0;
      rxByte_q <= 8'h00;
      rxAddr_q <= 1'b0;
      byteValid_q <= 1'b0;
    end
    else
    begin
      capByte_q <= byte_q;
      capAddr_q <= isAddr_q;
      rxByte_q <= capByte_q;
      rxAddr_q <= capAddr_q;
      byteValid_q <= byteArrived;
    end
  end

  wire addrStrobe = byteValid_q && rxAddr_q;
  wire dataStrobe = byteValid_q && !rxAddr_q && selected_q;
  wire [1:0] regSel = rxByte_q[7:6];
  wire statusWr = dataStrobe && xferType_q == `XFER_STATUS && regSel == 2'h0;
  wire volumeWr = dataStrobe && xferType_q == `XFER_DATA && regSel == `SEL_VOLUME;
  wire emphWr = dataStrobe && xferType_q == `XFER_DATA && regSel == `SEL_EMPH;
  wire defaultWr = dataStrobe && xferType_q == `XFER_DATA && rxByte_q == `DEFAULT_BYTE;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      selected_q <= 1'b0;
      xferType_q <= `XFER_DATA;
    end
    else if (addrStrobe)
    begin
      selected_q <= rxByte_q[7:2] == `DEVICE_ADDR;
      xferType_q <= rxByte_q[1:0];
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      clkRatio_q <= `CLK_RATIO_RST;
      inputFormat_q <= `FORMAT_RST;
    end
    else if (statusWr)
    begin
      clkRatio_q <= rxByte_q[5:4];
      inputFormat_q <= rxByte_q[3:1];
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      volume_q <= `VOLUME_RST;
      emph_q <= `EMPH_RST;
      mute_q <= `MUTE_RST;
    end
    else if (defaultWr)
    begin
      volume_q <= `VOLUME_RST;
      emph_q <= `EMPH_RST;
      mute_q <= `MUTE_RST;
    end
    else if (volumeWr)
      volume_q <= rxByte_q[5:0];
    else if (emphWr)
    begin
      emph_q <= rxByte_q[4:3];
      mute_q <= rxByte_q[2];
    end
  end

  // Next volume code, so the registered attenuation tracks the stored code in the same cycle.
  wire [5:0] volumeD = defaultWr ? `VOLUME_RST : (volumeWr ? rxByte_q[5:0] : volume_q);
  // Attenuation in dB; codes past the cap read as silence.
  wire [5:0] attenRaw = (volumeD == 6'h00) ? 6'h00 : volumeD - 6'h01;
  wire [5:0] attenCap = (volumeD >= `VOL_MAX_CODE) ? `VOL_MAX_ATTEN : attenRaw;
  wire silent = volumeD > `VOL_MAX_CODE;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      attenDb_q <= 6'h00;
      silence_q <= 1'b0;
    end
    else
    begin
      attenDb_q <= attenCap;
      silence_q <= silent;
    end
  end

  assign clkRatio = clk_ratio_e'(clkRatio_q);
  assign inputFormat = in_format_e'(inputFormat_q);
  assign volumeCode = volume_q;
  assign attenDb = attenDb_q;
  assign silence = silence_q;
  assign emphasis = emphasis_e'(emph_q);
  assign softMute = mute_q;

  a_partial_no_change: assert property (@(posedge clk) disable iff (!rstN)
    !byteValid_q |=> $stable(volume_q) && $stable(clkRatio_q) && $stable(mute_q))
    else $error("Setting changed without a whole byte.");
  a_byte_pulse: assert property (@(posedge clk) disable iff (!rstN)
    byteValid_q |=> !byteValid_q)
    else $error("Byte handed over twice.");
  a_volume_store: assert property (@(posedge clk) disable iff (!rstN)
    volumeWr && rxByte_q != `DEFAULT_BYTE |=> volume_q == $past(rxByte_q[5:0]))
    else $error("Volume byte not stored.");
  a_ignore_sel01: assert property (@(posedge clk) disable iff (!rstN)
    dataStrobe && xferType_q == `XFER_DATA && regSel == `SEL_NONE |=> $stable(volume_q) && $stable(emph_q))
    else $error("Unused data byte changed a setting.");
  a_emph_store: assert property (@(posedge clk) disable iff (!rstN)
    emphWr |=> emph_q == $past(rxByte_q[4:3]) && mute_q == $past(rxByte_q[2]))
    else $error("Emphasis byte not stored.");
  a_status_store: assert property (@(posedge clk) disable iff (!rstN)
    statusWr |=> clkRatio_q == $past(rxByte_q[5:4]) && inputFormat_q == $past(rxByte_q[3:1]))
    else $error("Status byte not stored.");
  a_default_restore: assert property (@(posedge clk) disable iff (!rstN)
    defaultWr |=> volume_q == 6'h00 && emph_q == 2'h0 && !mute_q)
    else $error("Default byte did not restore settings.");
  a_type_select: assert property (@(posedge clk) disable iff (!rstN)
    addrStrobe |=> xferType_q == $past(rxByte_q[1:0]))
    else $error("Transfer type not taken from address.");
  a_foreign_addr: assert property (@(posedge clk) disable iff (!rstN)
    addrStrobe && rxByte_q[7:2] != `DEVICE_ADDR |=> !selected_q)
    else $error("Foreign address kept the decoder selected.");
  a_atten_map: assert property (@(posedge clk) disable iff (!rstN)
    volume_q >= 6'h01 && volume_q < `VOL_MAX_CODE |-> attenDb == volume_q - 6'h01 && !silence)
    else $error("Attenuation map wrong.");
  a_atten_cap: assert property (@(posedge clk) disable iff (!rstN)
    volume_q == `VOL_MAX_CODE |-> attenDb == `VOL_MAX_ATTEN && !silence)
    else $error("Cap volume code wrong.");
  a_low_codes: assert property (@(posedge clk) disable iff (!rstN)
    volume_q <= 6'h01 |-> attenDb == 6'h00 && !silence)
    else $error("Low volume codes not at full level.");
  a_silence_top: assert property (@(posedge clk) disable iff (!rstN)
    volume_q == 6'h3F |-> silence && attenDb == 6'h3C)
    else $error("Top volume code not silent.");
  a_mute_out: assert property (@(posedge clk) disable iff (!rstN)
    emphWr |=> softMute == $past(rxByte_q[2]))
    else $error("Mute output mismatch.");
endmodule
`default_nettype wire

/* File: verification/ctrl_link_host.sv */
// Purpose: Host model driving the serial control link.
// Assumes: Data changes while the link clock is low.
// Notes: Between frames the clock stands still and data shows its inverse.
`timescale 1ns/10ps
`default_nettype none
module ctrl_link_host (
  // Serial control link.
  output logic linkClock,
  output logic linkData,
  output logic linkMode
);
  initial
  begin
    linkClock = 1'b0;
    linkData = 1'b0;
    linkMode = 1'b0;
  end
  // Sends the low n bits of a byte, LSB first, at an 80 ns link period.
  task automatic send(input logic mode, input logic [7:0] value, input int n);
    #3 linkMode = mode;
    for (int i = 0; i < n; i++)
    begin
      linkData = value[i];
      #40 linkClock = 1'b1;
      #40 linkClock = 1'b0;
    end
    #20 linkData = ~linkData;
    #20;
  endtask
endmodule
`default_nettype wire

/* File: verification/audio_dac_control_byte_decoder_bench.sv */
// Purpose: Self-checking bench for the control byte decoder.
// Assumes: Host model sends whole address and data phases, plus partial data phases of 2 or 5 bits.
// Notes: Expected settings are tracked in the bench.
`include "dac_ctrl_params.svh"
`timescale 1ns/10ps
`default_nettype none
module audio_dac_control_byte_decoder_bench;
  import dac_ctrl_pkg::*;
  localparam logic [7:0] statusAddr = {`DEVICE_ADDR, `XFER_STATUS};
  localparam logic [7:0] dataAddr = {`DEVICE_ADDR, `XFER_DATA};
  logic clk;
  logic reset_n;
  wire sClk;
  wire sData;
  wire sMode;
  clk_ratio_e clkRatio;
  in_format_e inputFormat;
  emphasis_e emphasis;
  logic [5:0] volumeCode;
  logic [5:0] attenDb;
  logic silence;
  logic softMute;
  logic [1:0] eRatio = 2'h0;
  logic [2:0] eFmt = 3'h0;
  logic [5:0] eVol = 6'h00;
  logic [1:0] eEmph = 2'h0;
  logic eMute = 1'b0;
  logic [5:0] vols [7] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h20, 6'h3C, 6'h3F};
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  ctrl_link_host hostU (.linkClock(sClk), .linkData(sData), .linkMode(sMode));
  audio_dac_control_byte_decoder dut_u (.clk(clk), .reset_n(reset_n), .ctrl_serial_clock(sClk),
    .ctrl_serial_data(sData), .ctrl_address_mode(sMode), .clkRatio(clkRatio), .inputFormat(inputFormat),
    .volumeCode(volumeCode), .attenDb(attenDb), .silence(silence), .emphasis(emphasis), .softMute(softMute));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic checkAll();
    logic [5:0] atten;
    atten = (eVol < 6'h02) ? 6'h00 : (eVol >= 6'h3C) ? 6'h3C : eVol - 6'h01;
    repeat (12) @(posedge clk);
    #1;
    check(clkRatio, eRatio);
    check(inputFormat, eFmt);
    check(volumeCode, eVol);
    check(attenDb, atten);
    check(silence, eVol > 6'h3C);
    check(emphasis, eEmph);
    check(softMute, eMute);
  endtask
  task automatic write(input logic [7:0] addr, input logic [7:0] value);
    hostU.send(1'b1, addr, 8);
    hostU.send(1'b0, value, 8);
    checkAll();
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  initial
  begin
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    hostU.send(1'b0, 8'h00, 2);
    checkAll();
    for (int r = 0; r < 3; r++)
      for (int f = 0; f < 5; f++)
      begin
        eRatio = 2'(r);
        eFmt = 3'(f);
        write(statusAddr, {2'b00, eRatio, eFmt, 1'b0});
      end
    foreach (vols[i])
    begin
      eVol = vols[i];
      write(dataAddr, {2'b00, eVol});
    end
    for (int e = 0; e < 4; e++)
    begin
      eEmph = 2'(e);
      eMute = e[0];
      write(dataAddr, {3'b100, eEmph, eMute, 2'b00});
    end
    write(dataAddr, 8'h7F);
    write(statusAddr, 8'h80);
    write({6'h06, `XFER_DATA}, 8'h05);
    write({`DEVICE_ADDR, 2'h1}, 8'h05);
    hostU.send(1'b1, dataAddr, 8);
    hostU.send(1'b0, 8'h2A, 5);
    checkAll();
    hostU.send(1'b1, dataAddr, 8);
    hostU.send(1'b0, 8'h0A, 8);
    hostU.send(1'b0, 8'h94, 8);
    eVol = 6'h0A;
    eEmph = 2'h2;
    eMute = 1'b1;
    checkAll();
    eVol = `VOLUME_RST;
    eEmph = `EMPH_RST;
    eMute = `MUTE_RST;
    write(dataAddr, `DEFAULT_BYTE);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    hostU.send(1'b0, 8'h00, 2);
    eRatio = `CLK_RATIO_RST;
    eFmt = `FORMAT_RST;
    checkAll();
    print_verdict();
  end
endmodule
`default_nettype wire
